/* rtl/host_serial_port.sv */
`include "serial_cfg_params.svh"
`default_nettype none
module host_serial_port
  import serial_cfg_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Configuration settings
  input wire logic [31:0] line_rate_setting_in,
  input wire logic [1:0] parity_setting_in,
  input wire logic stop_bit_setting_in,
  input wire logic [7:0] packetization_timeout_in,
  input wire logic [1:0] framing_mode_setting_in,
  input wire logic [1:0] receive_frame_option_in,
  input wire logic [2:0] cts_pin_function_in,
  input wire logic [2:0] rts_pin_function_in,
  input wire logic spi_host_in,
  input wire logic stack_profile_busy_in,
  // Serial lines
  input wire logic serial_rx_in,
  output logic serial_tx_out,
  // Shared io lines, output enables low while driving
  input wire logic cts_shared_io_line_in,
  output logic cts_shared_io_line_out,
  output logic cts_shared_io_line_oe_n_out,
  input wire logic rts_shared_io_line_in,
  output logic rts_shared_io_line_out,
  output logic rts_shared_io_line_oe_n_out,
  // Outgoing character stream to the host
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out,
  // Received characters and packet boundaries
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  output logic rx_parity_err_out,
  output logic packet_send_out,
  // Status
  output logic [31:0] line_rate_out,
  output logic [1:0] effective_framing_out,
  output logic [7:0] rx_frame_type_out,
  output logic zdo_passthrough_out,
  output logic host_may_send_out,
  output logic cts_pin_level_out,
  output logic rts_pin_level_out
);
  import serial_cfg_pkg::*;

  // ------------------------------------------------------------
  // Rate selection
  // ------------------------------------------------------------
  function automatic logic [31:0] code_rate(input logic [31:0] s);
    case (s[3:0])
      4'h0: code_rate = 32'd1200;
      4'h1: code_rate = 32'd2400;
      4'h2: code_rate = 32'd4800;
      4'h3: code_rate = 32'd9600;
      4'h4: code_rate = 32'd19200;
      4'h5: code_rate = 32'd38400;
      4'h6: code_rate = 32'd57600;
      4'h7: code_rate = 32'd115200;
      4'h8: code_rate = 32'd230400;
      4'h9: code_rate = 32'd460800;
      default: code_rate = 32'd921600;
    endcase
  endfunction

  // Above 0x0A the value is a literal rate; high rates are taken but divide coarsely
  wire [31:0] sel_rate = (line_rate_setting_in > `RATE_CODE_MAX) ? line_rate_setting_in :
                         code_rate(line_rate_setting_in);
  wire [31:0] raw_div = `CLK_HZ / ((sel_rate == 32'h0) ? 32'h1 : sel_rate);
  wire [31:0] bit_cycles = (raw_div == 32'h0) ? 32'h1 : raw_div;
  wire [31:0] half_cycles = {1'b0, bit_cycles[31:1]};
  wire [3:0] char_bits = 4'h9 + {3'h0, parity_setting_in != 2'h0} +
                         {3'h0, stop_bit_setting_in} + 4'h1;

  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  wire [1:0] eff_framing = spi_host_in ? FRM_FRAMED : framing_mode_setting_in;
  wire transparent = (eff_framing == FRM_TRANSPARENT);
  wire [7:0] frame_type = (receive_frame_option_in == 2'h0) ? `STD_FRAME_TYPE :
                          `EXPLICIT_FRAME_TYPE;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic rx_s1, rx_s2, cts_s1, cts_s2, rts_s1, rts_s2;
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      {rx_s1, rx_s2, cts_s1, cts_s2, rts_s1, rts_s2} <= 6'h3F;
    end else begin
      rx_s1 <= serial_rx_in;
      rx_s2 <= rx_s1;
      cts_s1 <= cts_shared_io_line_in;
      cts_s2 <= cts_s1;
      rts_s1 <= rts_shared_io_line_in;
      rts_s2 <= rts_s1;
    end
  end

  // ------------------------------------------------------------
  // Receiver
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    RX_IDLE = 2'h0,
    RX_BITS = 2'h1,
    RX_DONE = 2'h2
  } rx_state_t;
  rx_state_t rx_state;
  logic [31:0] rx_cnt;
  logic [3:0] rx_idx;
  logic [10:0] rx_shreg;
  wire rx_tick = (rx_cnt == 32'h0);
  wire [7:0] rx_byte = rx_shreg[8:1];
  wire rx_par_calc = (parity_setting_in == PAR_EVEN) ? ^rx_byte :
                     (parity_setting_in == PAR_ODD) ? ~^rx_byte : 1'b1;
  wire rx_par_bad = (parity_setting_in != PAR_NONE) && (rx_shreg[9] != rx_par_calc);
  // Only the first stop bit is sampled, a second one is idle time
  wire [3:0] rx_len = 4'h9 + {3'h0, parity_setting_in != PAR_NONE} + 4'h1;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rx_state <= RX_IDLE;
      rx_cnt <= 32'h0;
      rx_idx <= 4'h0;
      rx_shreg <= 11'h0;
      rx_valid_out <= 1'b0;
      rx_data_out <= 8'h00;
      rx_parity_err_out <= 1'b0;
    end else begin
      rx_valid_out <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          if (!rx_s2) begin
            rx_state <= RX_BITS;
            rx_cnt <= half_cycles;
            rx_idx <= 4'h0;
          end
        end
        RX_BITS: begin
          if (rx_tick) begin
            rx_shreg[rx_idx] <= rx_s2;
            rx_idx <= rx_idx + 4'h1;
            rx_cnt <= bit_cycles - 32'h1;
            if (rx_idx == 4'h0 && rx_s2) begin
              rx_state <= RX_IDLE;
            end else if (rx_idx == rx_len - 4'h1) begin
              rx_state <= RX_DONE;
            end
          end else begin
            rx_cnt <= rx_cnt - 32'h1;
          end
        end
        RX_DONE: begin
          rx_valid_out <= 1'b1;
          rx_data_out <= rx_byte;
          rx_parity_err_out <= rx_par_bad;
          rx_state <= RX_IDLE;
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Packetization silence timer
  // ------------------------------------------------------------
  logic [31:0] char_cnt;
  logic [3:0] bit_in_char;
  logic [7:0] silence;
  logic pending;
  wire char_time_tick = (char_cnt == 32'h0) && (bit_in_char == 4'h0);
  wire timeout_hit = (packetization_timeout_in == 8'h00) ||
                     (silence + 8'h1 >= packetization_timeout_in);

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      char_cnt <= 32'h0;
      bit_in_char <= 4'h0;
      silence <= 8'h00;
      pending <= 1'b0;
      packet_send_out <= 1'b0;
    end else begin
      packet_send_out <= 1'b0;
      if (rx_valid_out) begin
        char_cnt <= bit_cycles - 32'h1;
        bit_in_char <= char_bits - 4'h1;
        silence <= 8'h00;
        if (transparent && packetization_timeout_in == 8'h00) begin
          packet_send_out <= 1'b1;
          pending <= 1'b0;
        end else begin
          pending <= transparent;
        end
      end else if (char_cnt != 32'h0) begin
        char_cnt <= char_cnt - 32'h1;
      end else if (bit_in_char != 4'h0) begin
        char_cnt <= bit_cycles - 32'h1;
        bit_in_char <= bit_in_char - 4'h1;
      end else if (pending && transparent) begin
        char_cnt <= bit_cycles - 32'h1;
        bit_in_char <= char_bits - 4'h1;
        if (timeout_hit) begin
          packet_send_out <= 1'b1;
          pending <= 1'b0;
        end else begin
          silence <= silence + 8'h1;
        end
      end else if (!transparent) begin
        pending <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Transmitter
  // ------------------------------------------------------------
  logic tx_busy;
  logic tx_line;
  wire rts_flow = (rts_pin_function_in == PIN_FLOW);
  wire host_ready = !rts_flow || !rts_s2;
  wire tx_start = tx_valid_in && tx_ready_out;

  uart_char_tx u_char_tx (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .bit_cycles_in(bit_cycles),
    .parity_in(parity_setting_in),
    .two_stop_in(stop_bit_setting_in),
    .start_in(tx_start),
    .data_in(tx_data_in),
    .busy_out(tx_busy),
    .line_out(tx_line)
  );

  // ------------------------------------------------------------
  // Pin functions and registered outputs
  // ------------------------------------------------------------
  // Clear-to-send is active low; it goes high to hold the host off
  wire cts_blocked = stack_profile_busy_in;
  wire cts_drive = (cts_pin_function_in == PIN_FLOW) ||
                   (cts_pin_function_in == PIN_OUT_LOW) ||
                   (cts_pin_function_in == PIN_OUT_HIGH) ||
                   (cts_pin_function_in == PIN_TXEN_LOW) ||
                   (cts_pin_function_in == PIN_TXEN_HIGH);
  wire cts_level = (cts_pin_function_in == PIN_FLOW) ? cts_blocked :
                   (cts_pin_function_in == PIN_OUT_HIGH) ? 1'b1 :
                   (cts_pin_function_in == PIN_TXEN_LOW) ? !tx_busy :
                   (cts_pin_function_in == PIN_TXEN_HIGH) ? tx_busy : 1'b0;
  wire rts_drive = (rts_pin_function_in == PIN_OUT_LOW) ||
                   (rts_pin_function_in == PIN_OUT_HIGH);
  wire rts_level = (rts_pin_function_in == PIN_OUT_HIGH);

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      serial_tx_out <= 1'b1;
      cts_shared_io_line_out <= 1'b0;
      cts_shared_io_line_oe_n_out <= 1'b1;
      rts_shared_io_line_out <= 1'b0;
      rts_shared_io_line_oe_n_out <= 1'b1;
      tx_ready_out <= 1'b0;
      line_rate_out <= 32'h0;
      effective_framing_out <= `FRAMING_DEFAULT;
      rx_frame_type_out <= `STD_FRAME_TYPE;
      zdo_passthrough_out <= 1'b0;
      host_may_send_out <= 1'b0;
      cts_pin_level_out <= 1'b1;
      rts_pin_level_out <= 1'b1;
    end else begin
      serial_tx_out <= tx_line;
      cts_shared_io_line_out <= cts_level;
      cts_shared_io_line_oe_n_out <= !cts_drive;
      rts_shared_io_line_out <= rts_level;
      rts_shared_io_line_oe_n_out <= !rts_drive;
      tx_ready_out <= !tx_busy && !tx_start && host_ready;
      line_rate_out <= sel_rate;
      effective_framing_out <= eff_framing;
      rx_frame_type_out <= frame_type;
      zdo_passthrough_out <= (receive_frame_option_in == 2'h3);
      host_may_send_out <= !cts_blocked;
      cts_pin_level_out <= cts_s2;
      rts_pin_level_out <= rts_s2;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_spi_forces_framed;
    @(posedge mclk_in) disable iff (rst_in)
      spi_host_in |=> effective_framing_out == 2'h1;
  endproperty
  a_spi_forces_framed: assert property (p_spi_forces_framed)
    else $error("framing not forced on spi link");

  property p_literal_rate;
    @(posedge mclk_in) disable iff (rst_in)
      (line_rate_setting_in > 32'h0000_000A) ##1 $stable(line_rate_setting_in)
        |-> line_rate_out == line_rate_setting_in;
  endproperty
  a_literal_rate: assert property (p_literal_rate)
    else $error("literal rate not used");

  property p_code_seven;
    @(posedge mclk_in) disable iff (rst_in)
      line_rate_setting_in == 32'h7 |=> line_rate_out == 32'd115200;
  endproperty
  a_code_seven: assert property (p_code_seven)
    else $error("rate code 7 wrong");

  property p_profile_blocks;
    @(posedge mclk_in) disable iff (rst_in)
      (stack_profile_busy_in && cts_pin_function_in == 3'h1)[*2]
        |-> cts_shared_io_line_out && !cts_shared_io_line_oe_n_out;
  endproperty
  a_profile_blocks: assert property (p_profile_blocks)
    else $error("cts asserted during profile change");

  property p_txen_high;
    @(posedge mclk_in) disable iff (rst_in)
      (cts_pin_function_in == 3'h7 && tx_busy) |=> cts_shared_io_line_out;
  endproperty
  a_txen_high: assert property (p_txen_high)
    else $error("tx enable not high while sending");

  property p_out_low;
    @(posedge mclk_in) disable iff (rst_in)
      cts_pin_function_in == 3'h4 |=> !cts_shared_io_line_out && !cts_shared_io_line_oe_n_out;
  endproperty
  a_out_low: assert property (p_out_low)
    else $error("cts output low not driven");

  property p_no_packet_framed;
    @(posedge mclk_in) disable iff (rst_in)
      (!transparent)[*2] |-> !packet_send_out;
  endproperty
  a_no_packet_framed: assert property (p_no_packet_framed)
    else $error("packet boundary outside transparent mode");

  property p_zero_timeout;
    @(posedge mclk_in) disable iff (rst_in)
      (rx_valid_out && transparent && packetization_timeout_in == 8'h00) |=> packet_send_out;
  endproperty
  a_zero_timeout: assert property (p_zero_timeout)
    else $error("character not forwarded at once");

  property p_start_bit;
    @(posedge mclk_in) disable iff (rst_in)
      tx_start |=> ##1 !serial_tx_out;
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("no start bit");
endmodule // host_serial_port
`default_nettype wire

/* inc/serial_cfg_params.svh */
// Behaviour
// - Rate codes 0x0..0xA map to fixed rates 1200 up to 921600.
// - Rate settings above 0x0A are used directly as bits per second.
// - Rates above 115200 are accepted, with no guarantee of accuracy.
// - Parity: 0 none, 1 even, 2 odd, 3 mark; default none.
// - Stop bits: 0 gives one, 1 gives two; default one.
// - Transparent mode sends after silence of N character times, default 3.
// - Timeout zero forwards each character at once.
// - Packetization timeout applies only in Transparent mode.
// - Framing mode: 0 transparent, 1 framed, 2 framed escaped; default 0.
// - On the SPI host link framing mode is forced to 1.
// - Receive option picks standard, explicit 0x91, or passthrough frame type.
// - Clear-to-send pin function codes 0,1,3,4,5; default flow control.
// - Clear-to-send codes 6 and 7 give RS-485 enable, low or high.
// - Request-to-send function codes 0,1,3,4,5; default 0, flow off.
// - Clear-to-send is deasserted while the stack profile changes.
`ifndef SERIAL_CFG_PARAMS_SVH
`define SERIAL_CFG_PARAMS_SVH

`define CLK_HZ 32'd20000000
`define RATE_DEFAULT 32'h0000_0003
`define RATE_CODE_MAX 32'h0000_000A
`define PARITY_DEFAULT 2'h0
`define STOP_DEFAULT 1'h0
`define TIMEOUT_DEFAULT 8'h03
`define FRAMING_DEFAULT 2'h0
`define RXOPT_DEFAULT 2'h0
`define CTS_FUNC_DEFAULT 3'h1
`define RTS_FUNC_DEFAULT 3'h0
`define EXPLICIT_FRAME_TYPE 8'h91
`define STD_FRAME_TYPE 8'h90
`define DATA_BITS 4'h8

`endif

/* inc/serial_cfg_pkg.sv */
`default_nettype none
package serial_cfg_pkg;
  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_EVEN = 2'h1,
    PAR_ODD = 2'h2,
    PAR_MARK = 2'h3
  } parity_t;
  typedef enum logic [1:0] {
    FRM_TRANSPARENT = 2'h0,
    FRM_FRAMED = 2'h1,
    FRM_ESCAPED = 2'h2
  } framing_t;
  typedef enum logic [2:0] {
    PIN_UNMON_IN = 3'h0,
    PIN_FLOW = 3'h1,
    PIN_DIG_IN = 3'h3,
    PIN_OUT_LOW = 3'h4,
    PIN_OUT_HIGH = 3'h5,
    PIN_TXEN_LOW = 3'h6,
    PIN_TXEN_HIGH = 3'h7
  } pin_func_t;
endpackage
`default_nettype wire

/* rtl/uart_char_tx.sv */
`include "serial_cfg_params.svh"
`default_nettype none
// Serialises one character: start, eight data LSB first, parity, stops.
module uart_char_tx (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Configuration
  input wire logic [31:0] bit_cycles_in,
  input wire logic [1:0] parity_in,
  input wire logic two_stop_in,
  // Character
  input wire logic start_in,
  input wire logic [7:0] data_in,
  output logic busy_out,
  output logic line_out
);
  logic [10:0] shreg;
  logic [3:0] bits_left;
  logic [31:0] cnt;
  wire parity_bit = (parity_in == 2'h1) ? ^data_in :
                    (parity_in == 2'h2) ? ~^data_in : 1'b1;
  wire has_par = (parity_in != 2'h0);
  wire [3:0] frame_len = 4'h9 + {3'h0, has_par} + {3'h0, two_stop_in} + 4'h1;
  wire bit_end = (cnt == 32'h0);

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      shreg <= 11'h7FF;
      bits_left <= 4'h0;
      cnt <= 32'h0;
      busy_out <= 1'b0;
      line_out <= 1'b1;
    end else if (!busy_out) begin
      if (start_in) begin
        shreg <= has_par ? {1'b1, parity_bit, data_in, 1'b0} : {2'h3, data_in, 1'b0};
        bits_left <= frame_len;
        cnt <= bit_cycles_in - 32'h1;
        busy_out <= 1'b1;
        line_out <= 1'b0;
      end
    end else if (bit_end) begin
      if (bits_left == 4'h1) begin
        busy_out <= 1'b0;
        line_out <= 1'b1;
      end else begin
        shreg <= {1'b1, shreg[10:1]};
        line_out <= shreg[1];
        cnt <= bit_cycles_in - 32'h1;
      end
      bits_left <= bits_left - 4'h1;
    end else begin
      cnt <= cnt - 32'h1;
    end
  end
endmodule // uart_char_tx
`default_nettype wire

/* sim/host_uart_model.sv */
`default_nettype none
// ------
// Host side serial partner
// ------
module host_uart_model #(
  parameter int BIT_CYC = 20
) (
  // Clock
  input wire logic mclk_in,
  // Line settings, matched to the device
  input wire logic [1:0] parity_in,
  input wire logic two_stop_in,
  input wire logic bad_parity_in,
  // Serial lines and flow control
  input wire logic line_in,
  output logic line_out,
  input wire logic cts_n_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rx_data;
  logic rx_par;
  int rx_count;
  initial begin
    line_out = 1'b1;
    rx_count = 0;
  end
  function automatic logic par_bit(input logic [7:0] d);
    return (parity_in == 2'h3) ? 1'b1 : ((^d) ^ (parity_in == 2'h2));
  endfunction
  task automatic bit_out(input logic v);
    line_out = v;
    repeat (BIT_CYC) @(posedge mclk_in);
  endtask
  // Waits on the device's clear-to-send before each character, never mid-frame
  task automatic send(input logic [7:0] d);
    @(posedge mclk_in);
    while (cts_n_in !== 1'b0) @(posedge mclk_in);
    #5;
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) bit_out(d[i]);
    if (parity_in != 2'h0) bit_out(par_bit(d) ^ bad_parity_in);
    bit_out(1'b1);
    if (two_stop_in) bit_out(1'b1);
  endtask
  // Samples the device's line at bit centres
  always begin
    @(negedge line_in);
    repeat (BIT_CYC / 2) @(posedge mclk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge mclk_in);
      rx_data[i] = line_in;
    end
    if (parity_in != 2'h0) begin
      repeat (BIT_CYC) @(posedge mclk_in);
      rx_par = line_in;
    end
    repeat (BIT_CYC) @(posedge mclk_in);
    rx_count++;
  end
endmodule // host_uart_model
`default_nettype wire

/* sim/host_serial_port_tb_top.sv */
`default_nettype none
module host_serial_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ------
  // Stimulus and wiring
  // ------
  localparam int BIT_CYC = 20;
  localparam int CYC_LIMIT = 40000;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [31:0] rate = 32'h000F_4240;
  logic [1:0] par = 2'h0;
  logic stop2 = 1'b0;
  logic [7:0] pto = 8'h03;
  logic [1:0] frm = 2'h0;
  logic [1:0] rxo = 2'h0;
  logic [2:0] cts_f = 3'h1;
  logic [2:0] rts_f = 3'h0;
  logic spi = 1'b0;
  logic busy = 1'b0;
  logic bad_par = 1'b0;
  logic cts_host = 1'b1;
  logic rts_host = 1'b0;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  wire host_line, tx_line, cts_out, cts_oe_n, rts_out, rts_oe_n, cts_wire, rts_wire;
  wire tx_ready, rx_valid, rx_perr, pkt, zdo, may_send, cts_lvl, rts_lvl;
  wire [7:0] rx_data;
  wire [7:0] ftype;
  wire [31:0] line_rate_o;
  wire [1:0] eff_frm;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  int rx_cnt = 0;
  int pkt_cnt = 0;
  int rx_cyc = 0;
  int pkt_cyc = 0;
  logic [7:0] rx_seen;
  logic rx_perr_seen;
  // Pin level is whoever has its enable on
  assign cts_wire = cts_oe_n ? cts_host : cts_out;
  assign rts_wire = rts_oe_n ? rts_host : rts_out;
  initial forever #25 mclk_in = ~mclk_in;
  host_serial_port u_dut (.mclk_in(mclk_in), .rst_in(rst_in), .line_rate_setting_in(rate),
    .parity_setting_in(par), .stop_bit_setting_in(stop2), .packetization_timeout_in(pto),
    .framing_mode_setting_in(frm), .receive_frame_option_in(rxo), .cts_pin_function_in(cts_f),
    .rts_pin_function_in(rts_f), .spi_host_in(spi), .stack_profile_busy_in(busy),
    .serial_rx_in(host_line), .serial_tx_out(tx_line), .cts_shared_io_line_in(cts_wire),
    .cts_shared_io_line_out(cts_out), .cts_shared_io_line_oe_n_out(cts_oe_n),
    .rts_shared_io_line_in(rts_wire), .rts_shared_io_line_out(rts_out),
    .rts_shared_io_line_oe_n_out(rts_oe_n), .tx_valid_in(tx_valid), .tx_data_in(tx_data),
    .tx_ready_out(tx_ready), .rx_valid_out(rx_valid), .rx_data_out(rx_data),
    .rx_parity_err_out(rx_perr), .packet_send_out(pkt), .line_rate_out(line_rate_o),
    .effective_framing_out(eff_frm), .rx_frame_type_out(ftype), .zdo_passthrough_out(zdo),
    .host_may_send_out(may_send), .cts_pin_level_out(cts_lvl), .rts_pin_level_out(rts_lvl));
  host_uart_model #(.BIT_CYC(BIT_CYC)) u_host (.mclk_in(mclk_in), .parity_in(par),
    .two_stop_in(stop2), .bad_parity_in(bad_par), .line_in(tx_line), .line_out(host_line),
    .cts_n_in(cts_wire));
  // ------
  // Monitors, checks and closing
  // ------
  always @(posedge mclk_in) begin
    cycles++;
    if (rx_valid === 1'b1) begin
      rx_cnt++;
      rx_cyc = cycles;
      rx_seen = rx_data;
      rx_perr_seen = rx_perr;
    end
    if (pkt === 1'b1) begin
      pkt_cnt++;
      pkt_cyc = cycles;
    end
    if (cycles == CYC_LIMIT) begin
      err_total++;
      $display("CHECK FAILED cycle_limit expected %0d seen %0d", CYC_LIMIT - 1, cycles);
      finish_test();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #5;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, err_total);
  endtask
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_rates();
    logic [31:0] tab [11] = '{32'h0000_04B0, 32'h0000_0960, 32'h0000_12C0, 32'h0000_2580,
      32'h0000_4B00, 32'h0000_9600, 32'h0000_E100, 32'h0001_C200, 32'h0003_8400,
      32'h0007_0800, 32'h000E_1000};
    for (int c = 0; c <= 10; c++) begin
      rate = 32'(c);
      tick(3);
      chk("line_rate", tab[c], line_rate_o);
    end
    rate = 32'h0000_000B;
    tick(3);
    chk("line_rate", 32'h0000_000B, line_rate_o);
    rate = 32'h000F_4240;
    tick(3);
    chk("line_rate", 32'h000F_4240, line_rate_o);
    end_test("rates");
  endtask
  task automatic t_modes();
    for (int m = 0; m < 3; m++) begin
      frm = 2'(m);
      spi = 1'b0;
      tick(3);
      chk("framing", m, eff_frm);
      spi = 1'b1;
      tick(3);
      chk("framing_spi", 1, eff_frm);
    end
    spi = 1'b0;
    frm = 2'h0;
    for (int o = 0; o < 4; o++) begin
      if (o == 2) continue;
      rxo = 2'(o);
      tick(3);
      chk("frame_type", (o == 0) ? 8'h90 : 8'h91, ftype);
      chk("passthrough", o == 3, zdo);
    end
    rxo = 2'h0;
    end_test("modes");
  endtask
  task automatic t_pins();
    for (int c = 0; c < 6; c++) begin
      if (c == 2) continue;
      cts_f = 3'(c);
      rts_f = 3'(c);
      tick(4);
      chk("cts_oe_n", c == 0 || c == 3, cts_oe_n);
      chk("rts_oe_n", c < 4, rts_oe_n);
      chk("cts_level", !(c == 1 || c == 4), cts_lvl);
      chk("rts_level", c == 5, rts_lvl);
    end
    cts_f = 3'h1;
    rts_f = 3'h0;
    busy = 1'b1;
    tick(4);
    chk("cts_busy", 1, cts_out);
    chk("may_send_busy", 0, may_send);
    busy = 1'b0;
    tick(4);
    chk("cts_free", 0, cts_out);
    chk("may_send_free", 1, may_send);
    end_test("pins");
  endtask
  // Sends one character and judges its frame length and the enable pin
  task automatic do_tx(input logic [7:0] d);
    int n;
    int bits;
    int seen;
    seen = u_host.rx_count;
    bits = 10 + int'(par != 2'h0) + int'(stop2);
    tx_data = d;
    tx_valid = 1'b1;
    n = 0;
    @(posedge mclk_in);
    while (tx_ready !== 1'b1 && n < 500) begin
      n++;
      @(posedge mclk_in);
    end
    #5;
    tx_valid = 1'b0;
    tick(40);
    chk("txen_busy", cts_f == 3'h7, cts_out);
    n = 41;
    while (tx_ready !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    chk("tx_len_ok", 1, n >= bits * BIT_CYC && n <= bits * BIT_CYC + 6);
    tick(15);
    chk("txen_idle", cts_f == 3'h6, cts_out);
    chk("tx_count", seen + 1, u_host.rx_count);
    chk("tx_char", d, u_host.rx_data);
    if (par != 2'h0) chk("tx_parity", u_host.par_bit(d), u_host.rx_par);
  endtask
  task automatic t_tx();
    for (int k = 0; k < 8; k++) begin
      par = 2'(k % 4);
      stop2 = k > 3;
      cts_f = (k % 2) ? 3'h7 : 3'h6;
      tick(3);
      do_tx(8'(8'h1D * (k + 1)));
    end
    cts_f = 3'h1;
    par = 2'h0;
    stop2 = 1'b0;
    tick(3);
    end_test("tx");
  endtask
  task automatic t_rts();
    rts_f = 3'h1;
    rts_host = 1'b1;
    // Held-off level must pass the pin synchroniser before a character is offered
    tick(4);
    tx_data = 8'h5A;
    tx_valid = 1'b1;
    tick(10);
    chk("tx_ready_held", 0, tx_ready);
    chk("tx_line_held", 1, tx_line);
    rts_host = 1'b0;
    do_tx(8'h5A);
    rts_f = 3'h0;
    end_test("rts");
  endtask
  task automatic t_rx();
    int c0;
    par = 2'h2;
    stop2 = 1'b1;
    tick(3);
    c0 = rx_cnt;
    u_host.send(8'h3C);
    tick(20);
    chk("rx_count", c0 + 1, rx_cnt);
    chk("rx_char", 8'h3C, rx_seen);
    chk("rx_perr", 0, rx_perr_seen);
    bad_par = 1'b1;
    u_host.send(8'hC3);
    tick(20);
    bad_par = 1'b0;
    chk("rx_char", 8'hC3, rx_seen);
    chk("rx_perr", 1, rx_perr_seen);
    par = 2'h0;
    stop2 = 1'b0;
    end_test("rx");
  endtask
  task automatic t_packet();
    int p0;
    pto = 8'h00;
    // A boundary still pending from earlier received characters must flush first
    tick(300);
    p0 = pkt_cnt;
    u_host.send(8'h11);
    tick(60);
    chk("pkt_count", p0 + 1, pkt_cnt);
    chk("pkt_delay", 1, pkt_cyc - rx_cyc);
    pto = 8'h01;
    tick(3);
    p0 = pkt_cnt;
    u_host.send(8'h22);
    tick(700);
    chk("pkt_count", p0 + 1, pkt_cnt);
    chk("pkt_wait_ok", 1, pkt_cyc - rx_cyc >= 150 && pkt_cyc - rx_cyc <= 600);
    frm = 2'h1;
    pto = 8'h00;
    tick(3);
    p0 = pkt_cnt;
    u_host.send(8'h33);
    tick(700);
    chk("pkt_count", p0, pkt_cnt);
    frm = 2'h0;
    pto = 8'h03;
    end_test("packet");
  endtask
  initial begin
    repeat (16) @(posedge mclk_in);
    #5;
    chk("reset_tx_line", 1, tx_line);
    chk("reset_frame_type", 8'h90, ftype);
    rst_in = 1'b0;
    tick(3);
    chk("default_framing", 0, eff_frm);
    t_rates();
    t_modes();
    t_pins();
    t_tx();
    t_rts();
    t_rx();
    t_packet();
    finish_test();
  end
endmodule // host_serial_port_tb_top
`default_nettype wire
